// *** src/debug_comms_mailbox.sv ***
// two-way word mailbox between the core coprocessor port and the debug scan chain
// How it works
// - core reads host words from coprocessor register 1 (32 bits)
// - core writes words for the host to coprocessor register 1 (32 bits)
// - core reads handshake flags from coprocessor register 0
// - flags bit 1 is transmit-full: 0 free, 1 waiting for host
// - flags bit 0 is receive-full: 1 word waiting for core
// - a core write of transmit data sets transmit-full
// - host reading transmit data through the scan chain clears transmit-full
// - data and flags also sit at scan-chain addresses for the host
// - transfers run while the core executes; no halt, no debug state
// - host scanning a word into receive data sets receive-full
// - core reading receive data clears receive-full in the same read
// - receive-pending and transmit-ready outputs feed an interrupt controller
`timescale 1ns/1ps
module debug_comms_mailbox
    import dcc_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    input  wire cp_req_t     CP_REQ,
    output logic [31:0]      CP_RDATA,
    output logic             CP_RVALID,
    input  wire logic        SCAN_TCK,
    input  wire logic        SCAN_SEL,
    input  wire logic        SCAN_TDI,
    output logic             SCAN_TDO,
    output logic             RECEIVE_PENDING_IRQ,
    output logic             TRANSMIT_READY_IRQ
);
    logic        rx_full_reg;
    logic        tx_full_reg;
    logic [31:0] host_to_core_data_reg;
    logic [31:0] core_to_host_data_reg;
    logic [31:0] cp_rdata_reg;
    logic        cp_rvalid_reg;
    logic [SCAN_LEN-1:0] shift_reg;
    logic [31:0] capture_reg;
    logic [5:0]  bit_cnt_reg;
    scan_state_t state_reg;
    scan_state_t state_next;
    logic        tck_rise;
    logic        sel_start;
    logic        sel_end;
    logic        tdi;
    scan_frame_t frame;
    logic        frame_ok;
    logic        host_wr_data;
    logic        host_rd_data;
    logic        core_wr_data;
    logic        core_rd_data;
    logic        core_rd_flags;
    logic [31:0] flags_word;

    // the word both ports see when they read the flags
    function automatic logic [31:0] pack_flags(input logic rx_full, input logic tx_full);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[FLAG_RX_FULL] = rx_full;
        w[FLAG_TX_FULL] = tx_full;
        return w;
    endfunction : pack_flags

    // a coprocessor access of the given register
    function automatic logic cp_hit(input logic en, input logic [3:0] creg, input logic [3:0] want);
        return en && (creg == want);
    endfunction : cp_hit

    scan_pin_sync u_sync (
        .clk       (SYS_CLK),
        .rst_b     (RST_B),
        .tck_pin   (SCAN_TCK),
        .sel_pin   (SCAN_SEL),
        .tdi_pin   (SCAN_TDI),
        .tck_rise  (tck_rise),
        .sel_start (sel_start),
        .sel_end   (sel_end),
        .tdi       (tdi)
    );

    assign flags_word = pack_flags(rx_full_reg, tx_full_reg);

    // core side decode; the core never waits on the host
    assign core_wr_data  = cp_hit(CP_REQ.wr, CP_REQ.creg, CREG_DATA);
    assign core_rd_data  = cp_hit(CP_REQ.rd, CP_REQ.creg, CREG_DATA);
    assign core_rd_flags = cp_hit(CP_REQ.rd, CP_REQ.creg, CREG_FLAGS);

    // host side decode of a finished frame; short or long frames are dropped
    assign frame        = scan_frame_t'({shift_reg[SCAN_WR_BIT], shift_reg[SCAN_ADDR_LSB +: 5],
                                         shift_reg[SCAN_DATA_LSB +: 32]});
    assign frame_ok     = sel_end && (state_reg == SCAN_SHIFT) && (bit_cnt_reg == SCAN_LEN_CNT);
    assign host_wr_data = frame_ok && frame.wr && (frame.addr == SCAN_ADDR_DATA);
    assign host_rd_data = frame_ok && !frame.wr && (frame.addr == SCAN_ADDR_DATA);

    // core read answer, one cycle after the request
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cp_rdata_reg  <= DATA_RESET;
            cp_rvalid_reg <= 1'b0;
        end else begin
            cp_rvalid_reg <= CP_REQ.rd;
            if (core_rd_data) begin
                cp_rdata_reg <= host_to_core_data_reg;
            end else if (core_rd_flags) begin
                cp_rdata_reg <= flags_word;
            end
        end
    end

    // transmit word from the core
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            core_to_host_data_reg <= DATA_RESET;
        end else if (core_wr_data) begin
            core_to_host_data_reg <= CP_REQ.wdata;
        end
    end

    // receive word from the host
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            host_to_core_data_reg <= DATA_RESET;
        end else if (host_wr_data) begin
            host_to_core_data_reg <= frame.data;
        end
    end

    // transmit-full: a core write in the same cycle as a host read wins
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tx_full_reg <= TX_FULL_RESET;
        end else if (core_wr_data) begin
            tx_full_reg <= 1'b1;
        end else if (host_rd_data) begin
            tx_full_reg <= 1'b0;
        end
    end

    // receive-full: a host write in the same cycle as a core read wins
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rx_full_reg <= RX_FULL_RESET;
        end else if (host_wr_data) begin
            rx_full_reg <= 1'b1;
        end else if (core_rd_data) begin
            rx_full_reg <= 1'b0;
        end
    end

    // scan receiver: a frame opens on select rising and closes on select falling
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SCAN_IDLE: begin
                if (sel_start) begin
                    state_next = SCAN_SHIFT;
                end
            end
            SCAN_SHIFT: begin
                if (sel_end) begin
                    state_next = SCAN_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= SCAN_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // shift in lsb first; the count saturates so overlong frames stay invalid
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            shift_reg   <= '0;
            bit_cnt_reg <= 6'h00;
        end else if (sel_start) begin
            bit_cnt_reg <= 6'h00;
        end else if (state_reg == SCAN_SHIFT && tck_rise) begin
            shift_reg <= {tdi, shift_reg[SCAN_LEN-1:1]};
            if (bit_cnt_reg != 6'h3f) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
        end
    end

    // read results are loaded at frame end and shifted out during the next frame
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            capture_reg <= DATA_RESET;
        end else if (frame_ok && !frame.wr) begin
            if (frame.addr == SCAN_ADDR_DATA) begin
                capture_reg <= core_to_host_data_reg;
            end else if (frame.addr == SCAN_ADDR_FLAGS) begin
                capture_reg <= flags_word;
            end else begin
                capture_reg <= 32'h0000_0000; // unmapped address reads as zero
            end
        end else if (state_reg == SCAN_SHIFT && tck_rise) begin
            capture_reg <= {1'b0, capture_reg[31:1]};
        end
    end

    // output pins; sync latency of three cycles fits inside one scan half period
    assign SCAN_TDO            = capture_reg[0];
    assign CP_RDATA            = cp_rdata_reg;
    assign CP_RVALID           = cp_rvalid_reg;
    assign RECEIVE_PENDING_IRQ = rx_full_reg;
    assign TRANSMIT_READY_IRQ  = ~tx_full_reg;

endmodule : debug_comms_mailbox

// *** src/dcc_pkg.sv ***
// shared constants and types of the debug comms mailbox
package dcc_pkg;

    // coprocessor register numbers as seen by the core
    localparam logic [3:0]  CREG_FLAGS     = 4'h0;
    localparam logic [3:0]  CREG_DATA      = 4'h1;

    // handshake flag positions in the flags word
    localparam int          FLAG_RX_FULL   = 0;
    localparam int          FLAG_TX_FULL   = 1;

    // debug-logic addresses reached over the scan chain
    localparam logic [4:0]  SCAN_ADDR_FLAGS = 5'h04;
    localparam logic [4:0]  SCAN_ADDR_DATA  = 5'h05;

    // scan frame layout, shifted least significant bit first
    localparam int          SCAN_DATA_LSB  = 0;
    localparam int          SCAN_ADDR_LSB  = 32;
    localparam int          SCAN_WR_BIT    = 37;
    localparam int          SCAN_LEN       = 38;
    localparam logic [5:0]  SCAN_LEN_CNT   = 6'h26;

    // values after reset
    localparam logic        RX_FULL_RESET  = 1'b0;
    localparam logic        TX_FULL_RESET  = 1'b0;
    localparam logic [31:0] DATA_RESET     = 32'h0000_0000;

    // scan clock timing: the sampled link clock must stay this long in each phase
    localparam int          SYS_CLK_PERIOD_NS = 20;
    localparam int          SCAN_HALF_MIN_NS  = 80;
    localparam int          SCAN_HALF_MIN_CYC = (SCAN_HALF_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // core coprocessor request, one cycle wide
    typedef struct packed {
        logic        rd;     // coproc_register_read
        logic        wr;     // coproc_register_write
        logic [3:0]  creg;
        logic [31:0] wdata;
    } cp_req_t;

    // decoded scan frame
    typedef struct packed {
        logic        wr;
        logic [4:0]  addr;
        logic [31:0] data;
    } scan_frame_t;

    // scan receiver state
    typedef enum logic [0:0] {
        SCAN_IDLE  = 1'b0,
        SCAN_SHIFT = 1'b1
    } scan_state_t;

endpackage : dcc_pkg

// *** src/scan_pin_sync.sv ***
// synchroniser and edge finder for the debug scan pins
`timescale 1ns/1ps
module scan_pin_sync
    import dcc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic tck_pin,
    input  wire logic sel_pin,
    input  wire logic tdi_pin,
    output logic      tck_rise,
    output logic      sel_start,
    output logic      sel_end,
    output logic      tdi
);
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic [2:0] last_reg;

    // three flops per pin; the second and third stages feed logic, the first never does
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
            last_reg <= 3'h0;
        end else begin
            meta_reg <= {tdi_pin, sel_pin, tck_pin};
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // edges come from the settled copies, so each edge fires once
    assign tck_rise  = sync_reg[0] & ~last_reg[0];
    assign sel_start = sync_reg[1] & ~last_reg[1];
    assign sel_end   = ~sync_reg[1] & last_reg[1];
    assign tdi       = sync_reg[2];

endmodule : scan_pin_sync

// *** tb/debug_comms_mailbox_chk.sv ***
// port checker for the debug comms mailbox
`timescale 1ns/1ps
module dcm_chk
    import dcc_pkg::*;
(
    input wire logic        SYS_CLK,
    input wire logic        RST_B,
    input wire cp_req_t     CP_REQ,
    input wire logic [31:0] CP_RDATA,
    input wire logic        CP_RVALID,
    input wire logic        SCAN_TCK,
    input wire logic        SCAN_SEL,
    input wire logic        SCAN_TDI,
    input wire logic        SCAN_TDO,
    input wire logic        RECEIVE_PENDING_IRQ,
    input wire logic        TRANSMIT_READY_IRQ
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    // core requests on the data and flags registers
    sequence s_drd; CP_REQ.rd && CP_REQ.creg == CREG_DATA; endsequence
    sequence s_dwr; CP_REQ.wr && CP_REQ.creg == CREG_DATA; endsequence
    sequence s_frd; CP_REQ.rd && CP_REQ.creg == CREG_FLAGS; endsequence
    property p_rv; CP_REQ.rd |=> CP_RVALID; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_fl; s_frd |=> CP_RDATA == {30'h0, !$past(TRANSMIT_READY_IRQ), $past(RECEIVE_PENDING_IRQ)}; endproperty
    a_fl: assert property (p_fl) else $error("flags word wrong");
    property p_ws; s_dwr |=> !TRANSMIT_READY_IRQ; endproperty
    a_ws: assert property (p_ws) else $error("write left tx free");
    property p_rc; s_drd |=> !RECEIVE_PENDING_IRQ; endproperty
    a_rc: assert property (p_rc) else $error("read left rx full");
    property p_tr; $rose(TRANSMIT_READY_IRQ) |-> !SCAN_SEL && !$past(CP_REQ.wr); endproperty
    a_tr: assert property (p_tr) else $error("tx freed outside frame end");
    property p_rr; $rose(RECEIVE_PENDING_IRQ) |-> !SCAN_SEL; endproperty
    a_rr: assert property (p_rr) else $error("rx set inside frame");
    property p_rh; RECEIVE_PENDING_IRQ && !CP_REQ.rd |=> RECEIVE_PENDING_IRQ; endproperty
    a_rh: assert property (p_rh) else $error("rx lost without read");
    property p_th; TRANSMIT_READY_IRQ && !CP_REQ.wr |=> TRANSMIT_READY_IRQ; endproperty
    a_th: assert property (p_th) else $error("tx set without write");
endmodule : dcm_chk

bind debug_comms_mailbox dcm_chk dcm_chk_inst (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .CP_REQ(CP_REQ),
    .CP_RDATA(CP_RDATA), .CP_RVALID(CP_RVALID), .SCAN_TCK(SCAN_TCK), .SCAN_SEL(SCAN_SEL),
    .SCAN_TDI(SCAN_TDI), .SCAN_TDO(SCAN_TDO), .RECEIVE_PENDING_IRQ(RECEIVE_PENDING_IRQ),
    .TRANSMIT_READY_IRQ(TRANSMIT_READY_IRQ));

// *** tb/scan_host.sv ***
// host debugger model on the scan pins
`timescale 1ns/1ps
module scan_host
    import dcc_pkg::*;
#(
    parameter int HALF = 80
)
(
    output logic      SCAN_TCK,
    output logic      SCAN_SEL,
    output logic      SCAN_TDI,
    input  wire logic SCAN_TDO
);
    // link clock stands still low between frames
    initial begin
        SCAN_TCK = 1'b0;
        SCAN_SEL = 1'b0;
        SCAN_TDI = 1'b1;
    end
    // one frame of n clocks, lsb first; q is the word shifted out
    task automatic frame(input logic wr, input logic [4:0] a, input logic [31:0] d, input int n,
                         output logic [31:0] q);
        scan_frame_t f;
        f = '{wr: wr, addr: a, data: d};
        q = 32'h0;
        SCAN_SEL = 1'b1;
        #HALF; // lead-in so the select edge is seen before the first clock
        for (int i = 0; i < n; i++) begin
            SCAN_TDI = f[i];
            #HALF;
            if (i < 32) q[i] = SCAN_TDO;
            SCAN_TCK = 1'b1;
            #HALF;
            SCAN_TCK = 1'b0;
        end
        #HALF;
        SCAN_SEL = 1'b0;
        SCAN_TDI = ~SCAN_TDI; // released line shows no stale level
        #(2 * HALF);
    endtask : frame
endmodule : scan_host

// *** tb/tb_debug_comms_mailbox.sv ***
// self-checking bench for the debug comms mailbox
`timescale 1ns/1ps
module tb_debug_comms_mailbox;
    import dcc_pkg::*;
    typedef struct packed {
        logic [31:0] h2c;
        logic [31:0] c2h;
    } row_t;
    row_t        rows [3] = '{'{32'h0000_0001, 32'hffff_ffff}, '{32'h8000_0000, 32'h0000_0000},
                              '{32'h5a5a_c3c3, 32'h8000_0001}};
    logic        sys_clk = 1'b0;
    logic        rst_b   = 1'b0;
    cp_req_t     cp_req  = '0;
    logic [31:0] cp_rdata;
    logic        cp_rvalid, tck, sel, tdi, tdo, rx_irq, tx_irq;
    int          fails = 0;
    int          checks = 0;
    int          cycles = 0;

    debug_comms_mailbox debug_comms_mailbox_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .CP_REQ(cp_req),
        .CP_RDATA(cp_rdata), .CP_RVALID(cp_rvalid), .SCAN_TCK(tck), .SCAN_SEL(sel), .SCAN_TDI(tdi),
        .SCAN_TDO(tdo), .RECEIVE_PENDING_IRQ(rx_irq), .TRANSMIT_READY_IRQ(tx_irq));
    scan_host scan_host_inst (.SCAN_TCK(tck), .SCAN_SEL(sel), .SCAN_TDI(tdi), .SCAN_TDO(tdo));

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk32

    task automatic chk1(input string nm, input logic e, input logic g);
        chk32(nm, {31'h0, e}, {31'h0, g});
    endtask : chk1

    // one-cycle core request; returns just after the answer edge
    task automatic cp(input logic rd, input logic wr, input logic [3:0] cr, input logic [31:0] wd);
        @(posedge sys_clk);
        cp_req <= '{rd: rd, wr: wr, creg: cr, wdata: wd};
        @(posedge sys_clk);
        cp_req <= '0;
        #1;
    endtask : cp

    task automatic cprd(input logic [3:0] cr, input logic [31:0] e);
        cp(1'b1, 1'b0, cr, 32'h0);
        chk1("read valid", 1'b1, cp_rvalid);
        chk32("read data", e, cp_rdata);
    endtask : cprd

    // hang guard, far above the few thousand cycles needed
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish;
        end
    end

    initial begin
        logic [31:0] q;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // full round trip per row; software polls the flags before each write
        foreach (rows[i]) begin
            cprd(CREG_FLAGS, 32'h0);
            cp(1'b0, 1'b1, CREG_DATA, rows[i].c2h);
            chk1("tx ready", 1'b0, tx_irq);
            cprd(CREG_FLAGS, 32'h2);
            scan_host_inst.frame(1'b0, SCAN_ADDR_DATA, 32'h0, SCAN_LEN, q);
            chk1("tx ready", 1'b1, tx_irq);
            scan_host_inst.frame(1'b1, SCAN_ADDR_DATA, rows[i].h2c, SCAN_LEN, q);
            chk32("host word", rows[i].c2h, q);
            chk1("rx pending", 1'b1, rx_irq);
            cprd(CREG_FLAGS, 32'h1);
            cprd(CREG_DATA, rows[i].h2c);
            chk1("rx pending", 1'b0, rx_irq);
        end
        cprd(4'h7, rows[2].h2c);
        // host polls flags before reading; writes to flags do nothing
        cp(1'b0, 1'b1, CREG_DATA, 32'h1234_5678);
        scan_host_inst.frame(1'b0, SCAN_ADDR_FLAGS, 32'h0, SCAN_LEN, q);
        scan_host_inst.frame(1'b0, SCAN_ADDR_DATA, 32'h0, SCAN_LEN, q);
        chk32("scan flags", 32'h2, q);
        scan_host_inst.frame(1'b1, SCAN_ADDR_FLAGS, 32'h3, SCAN_LEN, q);
        chk32("scan word", 32'h1234_5678, q);
        chk1("rx pending", 1'b0, rx_irq);
        // a frame one clock short is dropped whole
        scan_host_inst.frame(1'b1, SCAN_ADDR_DATA, 32'hdead_beef, SCAN_LEN - 1, q);
        chk1("rx pending", 1'b0, rx_irq);
        // unmapped read gives zero and leaves a waiting word alone
        cp(1'b0, 1'b1, CREG_DATA, 32'h0f0f_0f0f);
        scan_host_inst.frame(1'b0, 5'h00, 32'h0, SCAN_LEN, q);
        chk1("tx ready", 1'b0, tx_irq);
        scan_host_inst.frame(1'b0, SCAN_ADDR_FLAGS, 32'h0, SCAN_LEN, q);
        chk32("scan unmapped", 32'h0, q);
        // reset in mid-run with a word waiting, driven on the clock edge
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        chk1("tx ready", 1'b1, tx_irq);
        cprd(CREG_FLAGS, 32'h0);
        cp(1'b0, 1'b1, CREG_FLAGS, 32'hffff_ffff);
        chk1("tx ready", 1'b1, tx_irq);
        tally_and_finish;
    end
endmodule : tb_debug_comms_mailbox
